//--- rtl/oms_map.vh
// register map, field positions, reset values and timing figures
// for the motion sensor register bank; definitions only
`ifndef OMS_MAP_VH
`define OMS_MAP_VH

// ==========================================================
// register offsets
`define OMS_ADDR_CONFIG 7'h40
`define OMS_ADDR_STATUS 7'h41
`define OMS_ADDR_VMOTION 7'h42
`define OMS_ADDR_HMOTION 7'h43
`define OMS_ADDR_QUALITY 7'h44
`define OMS_ADDR_BRIGHT 7'h45
`define OMS_ADDR_DARK 7'h46
`define OMS_ADDR_BR_TOTAL 7'h47
`define OMS_ADDR_DUMP 7'h48
`define OMS_ADDR_EXP_HIGH 7'h49
`define OMS_ADDR_EXP_LOW 7'h4A
`define OMS_ADDR_INTERVAL 7'h4B

// ==========================================================
// configuration fields
`define OMS_CFG_RESET_BIT 7
`define OMS_CFG_PD_BIT 6
`define OMS_CFG_SHUTTER_BIT 5
`define OMS_CFG_AWAKE_BIT 0
`define OMS_CFG_WMASK 8'hE1

// ==========================================================
// reset values
`define OMS_RST_CONFIG 8'h00
`define OMS_RST_ZERO 8'h00
`define OMS_RST_DARK 6'h3F
`define OMS_RST_BRIGHT 6'h00

// ==========================================================
// timing
`define OMS_CLK_HZ 20000000
`define OMS_SLEEP_MS 1000
`define OMS_FRAME_RATE 1500
`define OMS_PORT_TIMEOUT_MS 90
`define OMS_SLEEP_CYC (`OMS_CLK_HZ / 1000 * `OMS_SLEEP_MS)
`define OMS_FRAME_CYC (`OMS_CLK_HZ / `OMS_FRAME_RATE)
`define OMS_TIMEOUT_CYC (`OMS_CLK_HZ / 1000 * `OMS_PORT_TIMEOUT_MS)

`endif

//--- rtl/oms_sync.v
// two flip-flop synchroniser, one per bit
// assumes inputs come from outside the clk_i domain
`timescale 1ns/1ps
module oms_sync #(
  parameter WIDTH = 2
) (
  // clock and reset
  input wire clk_i,
  input wire reset_n_i,
  // async in, synced out
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  // ==========================================================
  // stages
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      always @(posedge clk_i) begin
        if (!reset_n_i) begin
          // port pins idle high; low here would fake an edge after reset
          meta_reg[g] <= 1'b1;
          sync_reg[g] <= 1'b1;
        end else begin
          meta_reg[g] <= async_i[g];
          sync_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

  assign sync_o = sync_reg;

endmodule

//--- rtl/oms_motion_acc.v
// signed 8-bit motion accumulator, saturating, cleared when taken
// assumes delta and take come from logic on clk_i
`timescale 1ns/1ps
`include "oms_map.vh"
module oms_motion_acc (
  // clock and reset
  input wire clk_i,
  input wire reset_n_i,
  input wire clear_i,
  // motion in
  input wire delta_vld_i,
  input wire [7:0] delta_i,
  // report
  input wire take_i,
  output wire [7:0] count_o
);

  reg [7:0] count_reg;
  reg [7:0] count_next;
  wire [8:0] sum;

  assign sum = {count_reg[7], count_reg} + {delta_i[7], delta_i};

  // ==========================================================
  // accumulate
  always @* begin
    count_next = count_reg;
    if (take_i) begin
      // motion in the reporting cycle is kept, not lost
      count_next = delta_vld_i ? delta_i : 8'h00;
    end else if (delta_vld_i) begin
      if (sum[8] != sum[7]) begin
        count_next = sum[8] ? 8'h80 : 8'h7F;
      end else begin
        count_next = sum[7:0];
      end
    end
  end

  always @(posedge clk_i) begin
    if (!reset_n_i || clear_i) begin
      count_reg <= `OMS_RST_ZERO;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count_o = count_reg;

endmodule

//--- rtl/oms_regs.v
// register bank of the motion sensor behind its two-wire serial port
// assumes frame statistics arrive from imaging logic on clk_i;
// sck and sdio come from the controller and are synchronised here
//
// Operation
// - controller reads and writes registers over the two-wire serial port
// - configuration at 0x40, read/write, resets to 0x00
// - configuration bit 7 resets the part when one; zero does nothing
// - configuration bit 6 powers down all analog circuitry
// - bit 5 clear keeps LED lit up to a second; set follows shutter
// - bit 0 forces awake; clear sleeps after one idle second; 1500 fps
// - status at 0x41 gives product code, reserved zeros, awake bit
// - vertical motion at 0x42, signed count since last report, resets zero
// - reading vertical motion returns the count then clears it
// - surface quality at 0x44 is upper eight bits of feature count
// - surface quality saturates at 255, near zero without a surface
// - brightest pixel at 0x45, six bits, upper bits zero, reset zero
// - darkest pixel at 0x46, six bits, upper bits zero, reset 0x3f
// - pixel sum, image dump, exposure and interval decoded at 0x47-0x4B
// - writes to unassigned addresses ignored, reads return zero
// - writing 0x80 resets, keeps other bits, reset bit self-clears
`timescale 1ns/1ps
`include "oms_map.vh"
module oms_regs #(
  parameter SLEEP_CYCLES = `OMS_SLEEP_CYC,
  parameter FRAME_CYCLES = `OMS_FRAME_CYC,
  parameter TIMEOUT_CYCLES = `OMS_TIMEOUT_CYC,
  // arbitrary value, not tied to any part
  parameter [2:0] PRODUCT_CODE = 3'h5
) (
  // clock and reset
  input wire clk_i,
  input wire reset_n_i,
  // serial port
  input wire sck_i,
  input wire sdio_i,
  output reg sdio_o,
  output reg sdio_oe_o,
  // frame statistics
  input wire frame_done_i,
  input wire [7:0] frame_dx_i,
  input wire [7:0] frame_dy_i,
  input wire [8:0] feature_count_i,
  input wire [5:0] pixel_max_i,
  input wire [5:0] pixel_min_i,
  input wire [7:0] pixel_sum_i,
  input wire [15:0] exposure_i,
  input wire [7:0] interval_i,
  input wire [7:0] dump_data_i,
  input wire shutter_open_i,
  // sensor control
  output reg analog_shutdown_o,
  output reg led_o,
  output reg awake_o,
  output reg frame_start_o,
  output reg soft_reset_o,
  output reg dump_rearm_o,
  output reg dump_advance_o
);

  localparam ST_ADDR = 2'h0;
  localparam ST_WDATA = 2'h1;
  localparam ST_RDATA = 2'h2;

  wire [1:0] port_sync;
  wire sck_s;
  wire sdio_s;
  reg sck_d_reg;
  wire sck_rise;
  wire sck_fall;

  reg [1:0] state_reg;
  reg [2:0] bit_cnt_reg;
  reg [7:0] addr_reg;
  reg [7:0] wdata_reg;
  reg [7:0] rd_shift_reg;
  reg hold_reg;
  reg [31:0] tmo_cnt_reg;
  wire tmo_hit;
  wire [7:0] shift_in;

  reg [7:0] cfg_reg;
  reg soft_rst_reg;
  wire clear_all;
  reg [7:0] quality_reg;
  reg [5:0] bright_reg;
  reg [5:0] dark_reg;
  reg [7:0] br_total_reg;
  reg [15:0] exposure_reg;
  reg [7:0] interval_reg;
  reg [31:0] idle_cnt_reg;
  reg [31:0] frame_cnt_reg;

  reg [7:0] read_data;
  wire rd_take;
  wire wr_take;
  wire take_v;
  wire take_h;
  wire [7:0] vmotion;
  wire [7:0] hmotion;
  wire motion_seen;

  // ==========================================================
  // pin synchronisers and sck edges
  oms_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i({sck_i, sdio_i}),
    .sync_o(port_sync)
  );

  assign sck_s = port_sync[1];
  assign sdio_s = port_sync[0];

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      // matches idle-high sck, so no false rise follows reset
      sck_d_reg <= 1'b1;
    end else begin
      sck_d_reg <= sck_s;
    end
  end

  assign sck_rise = sck_s & ~sck_d_reg;
  assign sck_fall = ~sck_s & sck_d_reg;
  assign shift_in = {addr_reg[6:0], sdio_s};

  // ==========================================================
  // read decode
  always @* begin
    case (shift_in[6:0])
      `OMS_ADDR_CONFIG: read_data = cfg_reg;
      `OMS_ADDR_STATUS: read_data = {PRODUCT_CODE, 4'h0, awake_o};
      `OMS_ADDR_VMOTION: read_data = vmotion;
      `OMS_ADDR_HMOTION: read_data = hmotion;
      `OMS_ADDR_QUALITY: read_data = quality_reg;
      `OMS_ADDR_BRIGHT: read_data = {2'h0, bright_reg};
      `OMS_ADDR_DARK: read_data = {2'h0, dark_reg};
      `OMS_ADDR_BR_TOTAL: read_data = br_total_reg;
      `OMS_ADDR_DUMP: read_data = dump_data_i;
      `OMS_ADDR_EXP_HIGH: read_data = exposure_reg[15:8];
      `OMS_ADDR_EXP_LOW: read_data = exposure_reg[7:0];
      `OMS_ADDR_INTERVAL: read_data = interval_reg;
      default: read_data = 8'h00;
    endcase
  end

  // address phase done with first bit low means read
  assign rd_take = (state_reg == ST_ADDR) && sck_rise &&
                   (bit_cnt_reg == 3'h7) && !addr_reg[6];
  assign wr_take = (state_reg == ST_WDATA) && sck_rise &&
                   (bit_cnt_reg == 3'h7);
  assign take_v = rd_take && (shift_in[6:0] == `OMS_ADDR_VMOTION);
  assign take_h = rd_take && (shift_in[6:0] == `OMS_ADDR_HMOTION);

  // ==========================================================
  // serial port engine
  // a stuck transaction is abandoned so controller can resync
  assign tmo_hit = (tmo_cnt_reg >= TIMEOUT_CYCLES - 1);

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      tmo_cnt_reg <= 32'h0;
    end else if (state_reg == ST_ADDR && bit_cnt_reg == 3'h0) begin
      tmo_cnt_reg <= 32'h0;
    end else begin
      tmo_cnt_reg <= tmo_cnt_reg + 32'h1;
    end
  end

  always @(posedge clk_i) begin
    if (!reset_n_i || tmo_hit) begin
      state_reg <= ST_ADDR;
      bit_cnt_reg <= 3'h0;
      addr_reg <= 8'h00;
      wdata_reg <= 8'h00;
      rd_shift_reg <= 8'h00;
      hold_reg <= 1'b0;
      sdio_o <= 1'b0;
      sdio_oe_o <= 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR: begin
          if (sck_fall && hold_reg) begin
            // last read bit held until this falling edge
            sdio_oe_o <= 1'b0;
            hold_reg <= 1'b0;
          end
          if (sck_rise) begin
            addr_reg <= shift_in;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
              if (addr_reg[6]) begin
                state_reg <= ST_WDATA;
              end else begin
                rd_shift_reg <= read_data;
                state_reg <= ST_RDATA;
              end
            end
          end
        end
        ST_WDATA: begin
          if (sck_rise) begin
            wdata_reg <= {wdata_reg[6:0], sdio_s};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
              state_reg <= ST_ADDR;
            end
          end
        end
        ST_RDATA: begin
          if (sck_fall) begin
            sdio_oe_o <= 1'b1;
            sdio_o <= rd_shift_reg[7];
            rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
          end
          if (sck_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
              hold_reg <= 1'b1;
              state_reg <= ST_ADDR;
            end
          end
        end
        default: begin
          state_reg <= ST_ADDR;
          bit_cnt_reg <= 3'h0;
        end
      endcase
    end
  end

  // ==========================================================
  // configuration and soft reset
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      cfg_reg <= `OMS_RST_CONFIG;
      soft_rst_reg <= 1'b0;
      dump_rearm_o <= 1'b0;
    end else begin
      soft_rst_reg <= cfg_reg[`OMS_CFG_RESET_BIT];
      dump_rearm_o <= wr_take &&
                      (addr_reg[6:0] == `OMS_ADDR_DUMP);
      if (wr_take && addr_reg[6:0] == `OMS_ADDR_CONFIG) begin
        // other bits of a reset write are kept
        cfg_reg <= {wdata_reg[6:0], sdio_s} & `OMS_CFG_WMASK;
      end else if (cfg_reg[`OMS_CFG_RESET_BIT]) begin
        cfg_reg[`OMS_CFG_RESET_BIT] <= 1'b0;
      end
    end
  end

  // soft reset clears counters, statistics and sleep state but not configuration or the serial port engine
  assign clear_all = soft_rst_reg;

  // ==========================================================
  // motion counters
  oms_motion_acc u_vmotion (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(clear_all),
    .delta_vld_i(frame_done_i),
    .delta_i(frame_dy_i),
    .take_i(take_v),
    .count_o(vmotion)
  );

  oms_motion_acc u_hmotion (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(clear_all),
    .delta_vld_i(frame_done_i),
    .delta_i(frame_dx_i),
    .take_i(take_h),
    .count_o(hmotion)
  );

  // ==========================================================
  // frame statistics
  always @(posedge clk_i) begin
    if (!reset_n_i || clear_all) begin
      quality_reg <= `OMS_RST_ZERO;
      bright_reg <= `OMS_RST_BRIGHT;
      dark_reg <= `OMS_RST_DARK;
      br_total_reg <= `OMS_RST_ZERO;
      exposure_reg <= 16'h0000;
      interval_reg <= `OMS_RST_ZERO;
    end else if (frame_done_i) begin
      // nine-bit count tops out at 255 after dropping bit 0
      quality_reg <= feature_count_i[8:1];
      bright_reg <= pixel_max_i;
      dark_reg <= pixel_min_i;
      br_total_reg <= pixel_sum_i;
      exposure_reg <= exposure_i;
      interval_reg <= interval_i;
    end
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      dump_advance_o <= 1'b0;
    end else begin
      dump_advance_o <= rd_take &&
                        (shift_in[6:0] == `OMS_ADDR_DUMP);
    end
  end

  // ==========================================================
  // sleep, frame pacing, analog and led control
  assign motion_seen = frame_done_i &&
                       ((frame_dx_i != 8'h00) || (frame_dy_i != 8'h00));

  always @(posedge clk_i) begin
    if (!reset_n_i || clear_all) begin
      idle_cnt_reg <= 32'h0;
      awake_o <= 1'b1;
    end else if (cfg_reg[`OMS_CFG_PD_BIT]) begin
      idle_cnt_reg <= 32'h0;
      awake_o <= 1'b0;
    end else if (motion_seen || cfg_reg[`OMS_CFG_AWAKE_BIT]) begin
      idle_cnt_reg <= 32'h0;
      awake_o <= 1'b1;
    end else if (idle_cnt_reg >= SLEEP_CYCLES - 1) begin
      awake_o <= 1'b0;
    end else begin
      idle_cnt_reg <= idle_cnt_reg + 32'h1;
    end
  end

  // frames only paced while awake; asleep the imager idles
  always @(posedge clk_i) begin
    if (!reset_n_i || clear_all || !awake_o) begin
      frame_cnt_reg <= 32'h0;
      frame_start_o <= 1'b0;
    end else if (frame_cnt_reg >= FRAME_CYCLES - 1) begin
      frame_cnt_reg <= 32'h0;
      frame_start_o <= 1'b1;
    end else begin
      frame_cnt_reg <= frame_cnt_reg + 32'h1;
      frame_start_o <= 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      analog_shutdown_o <= 1'b0;
      led_o <= 1'b0;
      soft_reset_o <= 1'b0;
    end else begin
      analog_shutdown_o <= cfg_reg[`OMS_CFG_PD_BIT];
      soft_reset_o <= soft_rst_reg;
      if (cfg_reg[`OMS_CFG_PD_BIT]) begin
        led_o <= 1'b0;
      end else if (cfg_reg[`OMS_CFG_SHUTTER_BIT]) begin
        led_o <= shutter_open_i;
      end else begin
        led_o <= awake_o;
      end
    end
  end

endmodule

//--- verification/oms_regs_properties.sv
// concurrent checks on the ports of the motion sensor register bank
// assumes the bench runs FRAME_CYCLES well above nine clocks
`timescale 1ns/1ps
module oms_regs_props (
  // clock and reset
  input wire clk_i,
  input wire reset_n_i,
  // inputs watched
  input wire sck_i,
  input wire frame_done_i,
  input wire [7:0] frame_dx_i,
  input wire [7:0] frame_dy_i,
  // outputs watched
  input wire sdio_o,
  input wire sdio_oe_o,
  input wire analog_shutdown_o,
  input wire led_o,
  input wire awake_o,
  input wire frame_start_o,
  input wire soft_reset_o,
  input wire dump_rearm_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // ==========================================================
  // reset, power down, soft reset
  rst_release_a: assert property ($rose(reset_n_i) |->
    !sdio_oe_o && awake_o && !analog_shutdown_o && !led_o)
    else $error("outputs not at reset values after release");
  pd_led_off_a: assert property (
    analog_shutdown_o && $past(analog_shutdown_o) |-> !led_o)
    else $error("led lit while powered down");
  pd_asleep_a: assert property (
    analog_shutdown_o && $past(analog_shutdown_o) |-> !awake_o)
    else $error("awake while powered down");
  soft_pulse_a: assert property (soft_reset_o |=> !soft_reset_o)
    else $error("soft reset pulse longer than one cycle");
  soft_awake_a: assert property (
    soft_reset_o && !analog_shutdown_o |-> awake_o)
    else $error("not awake after soft reset");
  // ==========================================================
  // frame pacing and sleep
  frame_gap_a: assert property (frame_start_o |=> !frame_start_o [*8])
    else $error("frame starts too close");
  frame_awake_a: assert property (frame_start_o |-> $past(awake_o))
    else $error("frame started while asleep");
  motion_wake_a: assert property (frame_done_i &&
    (frame_dx_i != 8'h00 || frame_dy_i != 8'h00) && !analog_shutdown_o
    |=> awake_o || analog_shutdown_o)
    else $error("motion did not wake the sensor");
  // ==========================================================
  // serial data and dump port
  data_hold_a: assert property (sdio_oe_o && $past(sdio_oe_o) &&
    $changed(sdio_o) |-> !$past(sck_i, 2))
    else $error("read data changed outside a clock low phase");
  rearm_pulse_a: assert property (dump_rearm_o |=> !dump_rearm_o)
    else $error("dump rearm pulse longer than one cycle");
  cover property (soft_reset_o);
  cover property ($fell(awake_o));
  cover property ($rose(sdio_oe_o));
  cover property (analog_shutdown_o);
endmodule

bind oms_regs oms_regs_props oms_regs_props_i (.clk_i, .reset_n_i, .sck_i,
  .frame_done_i, .frame_dx_i, .frame_dy_i, .sdio_o, .sdio_oe_o,
  .analog_shutdown_o, .led_o, .awake_o, .frame_start_o, .soft_reset_o,
  .dump_rearm_o);

//--- verification/oms_host_model.sv
// controller model for the two-wire port: address then data, msb first
// assumes the bench resolves sdio; each sck phase lasts four clk_i cycles
`timescale 1ns/1ps
module oms_host_model (
  // bench clock
  input wire clk_i,
  // serial pins
  output logic sck_o,
  output logic sdio_o,
  input wire sdio_i,
  // read result, one-cycle strobe
  output logic rd_vld_o,
  output logic [7:0] rd_data_o
);
  initial begin
    sck_o = 1'b1;
    sdio_o = 1'b1;
    rd_vld_o = 1'b0;
    rd_data_o = 8'h00;
  end
  // ==========================================================
  // one bit: drive on the fall, sample just before the rise
  task automatic bit_cyc(input logic drive, input logic val);
    @(negedge clk_i);
    sck_o <= 1'b0;
    // released line toggles so stale data never looks valid
    sdio_o <= drive ? val : ~sdio_o;
    repeat (4) @(negedge clk_i);
    rd_data_o <= {rd_data_o[6:0], sdio_i};
    sck_o <= 1'b1;
    repeat (3) @(negedge clk_i);
  endtask
  // ==========================================================
  // whole transaction; reads release sdio in the data phase
  task automatic xfer(input logic wr, input logic [6:0] a,
    input logic [7:0] d);
    logic [15:0] w;
    w = {wr, a, d};
    for (int i = 15; i >= 0; i--) begin
      bit_cyc(wr || i > 7, w[i]);
    end
    if (!wr) begin
      @(negedge clk_i);
      rd_vld_o <= 1'b1;
      @(negedge clk_i);
      rd_vld_o <= 1'b0;
    end
  endtask
endmodule

//--- verification/tb_oms_regs.sv
// bench for the register bank: host model on the port, frames from here
// assumes oms_regs_props is bound; inputs change on the falling edge
`timescale 1ns/1ps
module tb_oms_regs;
  localparam logic [2:0] PCODE = 3'h3; // arbitrary value, names no part
  logic clk_i = 1'b0;
  logic reset_n = 1'b0;
  logic fdone = 1'b0;
  logic [7:0] dx = 8'h00;
  logic [7:0] dy = 8'h00;
  logic [8:0] fcnt = 9'h000;
  logic [5:0] pmax = 6'h00;
  logic [5:0] pmin = 6'h00;
  logic [7:0] psum = 8'h00;
  logic [15:0] expo = 16'h0000;
  logic [7:0] ival = 8'h00;
  logic [7:0] dump = 8'h00;
  logic shut_open = 1'b0;
  logic [7:0] y1, y2, x1, x2, d;
  logic [14:0] exp_q[$];
  logic [14:0] e;
  wire sck, hsdio, sdio_d, oe_d, rd_vld, pd, led, awake, srst;
  wire rearm, adv;
  wire [7:0] rd_data;
  wire sdio_w = oe_d ? sdio_d : hsdio;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  int srst_cnt = 0;
  int rearm_cnt = 0;
  int adv_cnt = 0;
  always #25 clk_i = ~clk_i;
  oms_host_model oms_host_model_i (.clk_i(clk_i), .sck_o(sck),
    .sdio_o(hsdio), .sdio_i(sdio_w), .rd_vld_o(rd_vld),
    .rd_data_o(rd_data));
  oms_regs #(.SLEEP_CYCLES(200), .FRAME_CYCLES(20), .TIMEOUT_CYCLES(500),
    .PRODUCT_CODE(PCODE)) oms_regs_i (.clk_i(clk_i), .reset_n_i(reset_n),
    .sck_i(sck), .sdio_i(sdio_w), .sdio_o(sdio_d), .sdio_oe_o(oe_d),
    .frame_done_i(fdone), .frame_dx_i(dx), .frame_dy_i(dy),
    .feature_count_i(fcnt), .pixel_max_i(pmax), .pixel_min_i(pmin),
    .pixel_sum_i(psum), .exposure_i(expo), .interval_i(ival),
    .dump_data_i(dump), .shutter_open_i(shut_open),
    .analog_shutdown_o(pd), .led_o(led), .awake_o(awake),
    .frame_start_o(), .soft_reset_o(srst), .dump_rearm_o(rearm),
    .dump_advance_o(adv));
  // ==========================================================
  // compare, report, timeout
  task automatic chk(input string nm, input logic [7:0] ex,
    input logic [7:0] got);
    n_compared++;
    if (got !== ex) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // pulses counted mid-cycle, away from the edge that launches them
  always @(negedge clk_i) begin
    if (srst === 1'b1) srst_cnt++;
    if (rearm === 1'b1) rearm_cnt++;
    if (adv === 1'b1) adv_cnt++;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (rd_vld === 1'b1) begin
      e = exp_q.pop_front();
      chk($sformatf("reg %h", e[14:8]), e[7:0], rd_data);
    end
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ==========================================================
  // bus and frame helpers
  task automatic rd(input logic [6:0] a, input logic [7:0] ex);
    exp_q.push_back({a, ex});
    oms_host_model_i.xfer(1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    oms_host_model_i.xfer(1'b1, a, v);
  endtask
  task automatic frame(input logic [7:0] fx, input logic [7:0] fy);
    @(negedge clk_i);
    fdone = 1'b1;
    dx = fx;
    dy = fy;
    @(negedge clk_i);
    fdone = 1'b0;
  endtask
  task automatic pins(input logic [7:0] p_pd, input logic [7:0] p_aw);
    repeat (6) @(negedge clk_i);
    chk("shutdown", p_pd, {7'h00, pd});
    chk("awake", p_aw, {7'h00, awake});
    chk("led", p_aw, {7'h00, led});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(35929));
    repeat (6) @(negedge clk_i);
    reset_n = 1'b1;
    repeat (4) @(negedge clk_i);
    rd(7'h41, {PCODE, 5'h01});
    rd(7'h40, 8'h00);
    rd(7'h42, 8'h00);
    rd(7'h44, 8'h00);
    rd(7'h45, 8'h00);
    rd(7'h46, 8'h3F);
    $display("test reset values done");
    {fcnt, pmax, pmin, psum} = {$urandom, $urandom};
    {expo, ival, dump} = $urandom;
    frame(8'h00, 8'h00);
    rd(7'h44, fcnt[8:1]);
    rd(7'h45, {2'b00, pmax});
    rd(7'h46, {2'b00, pmin});
    rd(7'h47, psum);
    rd(7'h48, dump);
    rd(7'h49, expo[15:8]);
    rd(7'h4A, expo[7:0]);
    rd(7'h4B, ival);
    fcnt = 9'h1FF;
    frame(8'h00, 8'h00);
    rd(7'h44, 8'hFF);
    $display("test frame statistics done");
    y1 = 8'($urandom_range(120)) - 8'd60;
    y2 = 8'($urandom_range(120)) - 8'd60;
    x1 = 8'($urandom_range(120)) - 8'd60;
    x2 = 8'($urandom_range(120)) - 8'd60;
    frame(x1, y1);
    frame(x2, y2);
    rd(7'h42, y1 + y2);
    rd(7'h43, x1 + x2);
    rd(7'h42, 8'h00);
    rd(7'h43, 8'h00);
    $display("test motion done");
    d = {3'b001, 5'($urandom)};
    wr(7'h40, d);
    rd(7'h40, d & 8'hE1);
    for (int s = 1; s >= 0; s--) begin
      shut_open = s[0];
      repeat (4) @(negedge clk_i);
      chk("led", {7'h00, s[0]}, {7'h00, led});
    end
    $display("test config done");
    wr(7'h40, 8'h00);
    repeat (300) @(negedge clk_i);
    pins(8'h00, 8'h00);
    rd(7'h41, {PCODE, 5'h00});
    frame(8'h01, 8'h00);
    rd(7'h41, {PCODE, 5'h01});
    wr(7'h40, 8'h01);
    repeat (300) @(negedge clk_i);
    pins(8'h00, 8'h01);
    wr(7'h40, 8'h40);
    pins(8'h01, 8'h00);
    rd(7'h40, 8'h40);
    wr(7'h40, 8'h00);
    $display("test sleep and power down done");
    wr(7'h10, 8'h55);
    rd(7'h10, 8'h00);
    wr(7'h44, 8'h55);
    rd(7'h44, 8'hFF);
    wr(7'h48, 8'h55);
    rd(7'h4C, 8'h00);
    chk("dump rearm pulses", 8'h01, 8'(rearm_cnt));
    chk("dump advance pulses", 8'h01, 8'(adv_cnt));
    $display("test unmapped done");
    frame(8'h05, 8'h05);
    wr(7'h40, 8'hA1);
    rd(7'h40, 8'h21);
    rd(7'h42, 8'h00);
    rd(7'h41, {PCODE, 5'h01});
    chk("soft reset pulses", 8'h01, 8'(srst_cnt));
    $display("test soft reset done");
    report_and_stop();
  end
endmodule
